// ===== verilog/rsc_pkg.sv
// Constants and types shared by the reset source controller files.
// Assumes one system clock; all pins are asynchronous to it.
package rsc_pkg;

    // ************************************************************
    // Reset vector and status layout
    // ************************************************************
    localparam logic [15:0] RSC_RESET_VECTOR = 16'h8000;
    localparam int RSC_POR_FLAG_BIT = 7;
    localparam logic [7:0] RSC_WDCTL_RESET = 8'h80;

    // ************************************************************
    // Timing counts in system clock cycles
    // ************************************************************
    localparam int unsigned RSC_POWERUP_CYCLES = 65536;
    localparam int unsigned RSC_WDT_CYCLES = 4096;
    localparam logic [2:0] RSC_WDT_HOLD_LAST = 3'h3;  // Four cycles
    localparam logic [2:0] RSC_MAN_LOW_LAST = 3'h3;   // Four low samples
    localparam logic [1:0] RSC_BLANK_CYCLES = 2'h3;

    // ************************************************************
    // Pin synchroniser layout
    // ************************************************************
    localparam int RSC_SYNC_W = 4;
    localparam int RSC_IDX_CORE = 0;
    localparam int RSC_IDX_IO = 1;
    localparam int RSC_IDX_PFAIL = 2;
    localparam int RSC_IDX_PIN = 3;
    localparam logic [3:0] RSC_SYNC_RST = 4'h8;  // Reset pin idles high

    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [2:0] {
        RSC_POR_WAIT,
        RSC_POR_HOLD,
        RSC_RUN,
        RSC_PFAIL,
        RSC_WDT_RST,
        RSC_MAN_RST
    } rsc_state_e;

endpackage : rsc_pkg

// ===== verilog/rsc_sync.sv
// Two-flop synchroniser for the supply, power-fail and reset pins.
// Assumes inputs are asynchronous to clk_i; reset is synchronous.
module rsc_sync (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [rsc_pkg::RSC_SYNC_W-1:0] async_i,
    output logic [rsc_pkg::RSC_SYNC_W-1:0] sync_o
);
    import rsc_pkg::*;

    typedef struct packed {
        logic [RSC_SYNC_W-1:0] stage1;
        logic [RSC_SYNC_W-1:0] stage2;
    } rsc_sync_s;

    rsc_sync_s q;
    rsc_sync_s next_q;

    // ************************************************************
    // Shift chain; only stage2 is visible outside
    // ************************************************************
    always_comb begin
        next_q.stage1 = async_i;
        next_q.stage2 = q.stage1;
        if (!rstn_i) begin
            next_q.stage1 = RSC_SYNC_RST;
            next_q.stage2 = RSC_SYNC_RST;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        q <= next_q;
    end

    assign sync_o = q.stage2;

endmodule : rsc_sync

// ===== verilog/rsc_ctrl.sv
// Reset source controller: power-on hold, power fail, watchdog and
// manual reset through an open-drain active-low pin.
// Assumes rstn_i comes from the power-on detector, synchronous to clk_i;
// the pin wire is resolved outside from rst_pin_oe_o.

module rsc_ctrl #(
    parameter int unsigned POWERUP_CYCLES = rsc_pkg::RSC_POWERUP_CYCLES,
    parameter int unsigned WDT_CYCLES = rsc_pkg::RSC_WDT_CYCLES
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic core_supply_ok_i,
    input wire logic io_supply_ok_i,
    input wire logic power_fail_i,
    input wire logic rst_pin_i,
    output logic rst_pin_o,
    output logic rst_pin_oe_o,
    input wire logic wdt_reset_en_i,
    input wire logic wdt_irq_en_i,
    input wire logic wdt_restart_i,
    input wire logic por_flag_clr_i,
    input wire logic clk_switch_i,
    output logic wdt_irq_o,
    output logic [7:0] watchdog_control_reg_o,
    output logic clk_ring_sel_o,
    output logic sys_rst_o,
    output logic boot_o,
    output logic [15:0] fetch_addr_o
);
    import rsc_pkg::*;

    typedef struct packed {
        rsc_state_e state;
        logic [16:0] hold_cnt;
        logic [15:0] wdt_cnt;
        logic wdt_irq;
        logic [2:0] step_cnt;
        logic [2:0] low_cnt;
        logic [1:0] blank;
        logic por_flag;
        logic ring_sel;
        logic in_rst;
        logic drive;
        logic boot;
        logic [15:0] fetch_addr;
    } rsc_ctrl_s;

    rsc_ctrl_s q;
    rsc_ctrl_s next_q;
    logic [RSC_SYNC_W-1:0] pins_s;
    logic supplies_ok;
    logic pfail_s;
    logic pin_low;
    logic wdt_expire;

    // Internal sources that pull the pin low themselves
    function automatic logic drives_pin(input rsc_state_e st);
        drives_pin = (st == RSC_POR_WAIT) || (st == RSC_POR_HOLD) ||
                     (st == RSC_PFAIL) || (st == RSC_WDT_RST);
    endfunction : drives_pin

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    rsc_sync u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .async_i({rst_pin_i, power_fail_i, io_supply_ok_i,
                  core_supply_ok_i}),
        .sync_o(pins_s)
    );

    // Synchronised views of the pins, and the watchdog expiry decode
    assign supplies_ok = pins_s[RSC_IDX_CORE] && pins_s[RSC_IDX_IO];
    assign pfail_s = pins_s[RSC_IDX_PFAIL];
    assign pin_low = !pins_s[RSC_IDX_PIN];
    assign wdt_expire = (q.wdt_cnt == 16'(WDT_CYCLES - 1));

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        next_q = q;
        next_q.boot = 1'b0;
        next_q.hold_cnt = 17'h0;
        case (q.state)
            RSC_POR_WAIT: begin
                if (supplies_ok) begin
                    next_q.state = RSC_POR_HOLD;
                end
            end
            RSC_POR_HOLD: begin
                if (!supplies_ok) begin
                    next_q.state = RSC_POR_WAIT;
                end else if (q.hold_cnt ==
                             17'(POWERUP_CYCLES - 1)) begin
                    next_q.state = RSC_RUN;
                end else begin
                    next_q.hold_cnt = q.hold_cnt + 17'h1;
                end
            end
            RSC_RUN: begin
                // Watchdog count, restart and two-level expiry
                if (!wdt_reset_en_i) begin
                    next_q.wdt_cnt = 16'h0;
                    next_q.wdt_irq = 1'b0;
                end else if (wdt_expire) begin
                    next_q.wdt_cnt = 16'h0;
                    if (wdt_irq_en_i && !q.wdt_irq) begin
                        next_q.wdt_irq = 1'b1;
                    end else begin
                        next_q.state = RSC_WDT_RST;
                        next_q.step_cnt = 3'h0;
                    end
                end else if (wdt_restart_i) begin
                    next_q.wdt_cnt = 16'h0;
                    next_q.wdt_irq = 1'b0;
                end else begin
                    next_q.wdt_cnt = q.wdt_cnt + 16'h1;
                end
                // Manual reset qualified on four synchronised low samples
                if (pin_low && q.blank == 2'h0) begin
                    next_q.low_cnt = q.low_cnt + 3'h1;
                    if (q.low_cnt == RSC_MAN_LOW_LAST) begin
                        next_q.state = RSC_MAN_RST;
                    end
                end else begin
                    next_q.low_cnt = 3'h0;
                end
                if (q.blank != 2'h0) begin
                    next_q.blank = q.blank - 2'h1;
                end
                if (pfail_s) begin
                    next_q.state = RSC_PFAIL;
                end
                if (por_flag_clr_i) begin
                    next_q.por_flag = 1'b0;
                end
                if (clk_switch_i) begin
                    next_q.ring_sel = 1'b0;
                end
            end
            RSC_PFAIL: begin
                if (!pfail_s) begin
                    next_q.state = RSC_RUN;
                end
            end
            RSC_WDT_RST: begin
                next_q.step_cnt = q.step_cnt + 3'h1;
                if (q.step_cnt == RSC_WDT_HOLD_LAST) begin
                    next_q.state = RSC_RUN;
                end
            end
            RSC_MAN_RST: begin
                if (!pin_low) begin
                    next_q.state = RSC_RUN;
                end
            end
            default: begin
                next_q.state = RSC_POR_WAIT;
            end
        endcase
        // Any reset state clears the watchdog and manual qualifier
        if (next_q.state != RSC_RUN) begin
            next_q.wdt_cnt = 16'h0;
            next_q.wdt_irq = 1'b0;
            next_q.low_cnt = 3'h0;
        end
        // Blank own echo of the pin after releasing it
        if (q.drive && !drives_pin(next_q.state)) begin
            next_q.blank = RSC_BLANK_CYCLES;
        end
        next_q.in_rst = (next_q.state != RSC_RUN);
        next_q.drive = drives_pin(next_q.state);
        if (q.in_rst && !next_q.in_rst) begin
            next_q.boot = 1'b1;
            next_q.fetch_addr = RSC_RESET_VECTOR;
        end
        // Power-on reset puts everything into its reset state
        if (!rstn_i) begin
            next_q = '0;
            next_q.state = RSC_POR_WAIT;
            next_q.por_flag = 1'b1;
            next_q.ring_sel = 1'b1;
            next_q.in_rst = 1'b1;
            next_q.drive = 1'b1;
            next_q.fetch_addr = RSC_RESET_VECTOR;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        q <= next_q;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign rst_pin_o = 1'b0;  // Open drain: only ever pulls low
    assign rst_pin_oe_o = q.drive;
    assign wdt_irq_o = q.wdt_irq;
    // Only the power-on cause bit is live in the status byte
    always_comb begin
        watchdog_control_reg_o = 8'h0;
        watchdog_control_reg_o[RSC_POR_FLAG_BIT] = q.por_flag;
    end
    assign clk_ring_sel_o = q.ring_sel;
    assign sys_rst_o = q.in_rst;
    assign boot_o = q.boot;
    assign fetch_addr_o = q.fetch_addr;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    logic [16:0] hold_len;
    logic st_wdt;
    logic st_man;
    assign st_wdt = (q.state == RSC_WDT_RST);
    assign st_man = (q.state == RSC_MAN_RST);

    // Independent length of the power-up hold
    always_ff @(posedge clk_i) begin
        if (q.state == RSC_POR_HOLD) begin
            hold_len <= hold_len + 17'h1;
        end else begin
            hold_len <= 17'h0;
        end
    end

    wdt_hold_four_a: assert property (
        $rose(st_wdt) |-> st_wdt[*4] ##1 (!st_wdt && !sys_rst_o))
        else $error("watchdog reset not four cycles");
    pin_drive_a: assert property (
        (q.state inside {RSC_POR_WAIT, RSC_POR_HOLD, RSC_PFAIL,
                         RSC_WDT_RST}) |-> (rst_pin_oe_o && sys_rst_o))
        else $error("pin not driven during internal reset");
    man_exit_a: assert property (
        (st_man && rst_pin_i) ##1 rst_pin_i[*2] |-> ##1 !st_man)
        else $error("manual reset exit too slow");
    man_min_low_a: assert property (
        $rose(st_man) |-> ($past(pin_low, 1) && $past(pin_low, 2) &&
                           $past(pin_low, 3) && $past(pin_low, 4)))
        else $error("manual reset on short low");
    por_hold_len_a: assert property (
        (q.state == RSC_POR_HOLD && supplies_ok) ##1 (q.state == RSC_RUN)
        |-> $past(hold_len) == 17'(POWERUP_CYCLES - 1))
        else $error("power-up hold length wrong");
    hold_off_a: assert property (
        (q.state != RSC_POR_HOLD) |-> (q.hold_cnt == 17'h0))
        else $error("hold counter runs outside power-up");
    pfail_reset_a: assert property (
        (q.state == RSC_RUN && pfail_s) |=> (sys_rst_o && rst_pin_oe_o))
        else $error("power fail did not reset");
    por_state_a: assert property (
        (q.state == RSC_POR_WAIT) |-> (watchdog_control_reg_o[7] &&
                                        clk_ring_sel_o))
        else $error("power-on flag or clock select missing");
    boot_vector_a: assert property (
        $fell(sys_rst_o) |-> (boot_o && fetch_addr_o == RSC_RESET_VECTOR))
        else $error("restart not at reset vector");
    wdt_second_a: assert property (
        (q.state == RSC_RUN && wdt_reset_en_i && wdt_irq_o && wdt_expire &&
         !pfail_s) |=> st_wdt)
        else $error("watchdog did not reset after interrupt");

endmodule : rsc_ctrl

// ===== dv/rsc_supervisor.sv
// Model of the outside supervisor on the open-drain reset pin.
// Assumes a pull-up on the pin and the system clock of the bench.
module rsc_supervisor (
    input wire logic clk_i,
    input wire logic oe_i,
    output logic pin_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic pull;

    // Wired-AND of both pull-downs; the pull-up gives high otherwise
    assign pin_o = !(oe_i || pull);

    initial begin
        pull = 1'b0;
    end

    // Pull the pin low for a number of whole clock cycles
    task hold_low(input int cycles);
        @(posedge clk_i);
        #10;
        pull = 1'b1;
        repeat (cycles) @(posedge clk_i);
        #10;
        pull = 1'b0;
    endtask : hold_low
endmodule : rsc_supervisor

// ===== dv/test_reset_source_controller.sv
// Self-checking bench for the reset source controller.
// Assumes the design files and the supervisor model are compiled first.
module test_reset_source_controller;
    timeunit 1ns;
    timeprecision 100ps;
    import rsc_pkg::*;

    // ************************************************************
    // Signals and instances
    // ************************************************************
    localparam int PU = 16;
    localparam int WD = 8;
    logic clk_i, rstn_i, core_ok, io_ok, pfail, wen, ien, wrs, pclr, csw;
    logic pin, pin_val, oe, irq, ring, srst, boot;
    logic [7:0] wdc;
    logic [15:0] fa;
    int n_mismatch, tests_run, n;

    rsc_ctrl #(.POWERUP_CYCLES(PU), .WDT_CYCLES(WD)) i_rsc_ctrl (
        .clk_i(clk_i), .rstn_i(rstn_i), .core_supply_ok_i(core_ok),
        .io_supply_ok_i(io_ok), .power_fail_i(pfail), .rst_pin_i(pin),
        .rst_pin_o(pin_val), .rst_pin_oe_o(oe), .wdt_reset_en_i(wen),
        .wdt_irq_en_i(ien), .wdt_restart_i(wrs), .por_flag_clr_i(pclr),
        .clk_switch_i(csw), .wdt_irq_o(irq),
        .watchdog_control_reg_o(wdc), .clk_ring_sel_o(ring),
        .sys_rst_o(srst), .boot_o(boot), .fetch_addr_o(fa)
    );

    rsc_supervisor i_rsc_supervisor (
        .clk_i(clk_i), .oe_i(oe), .pin_o(pin)
    );

    // Free-running system clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task step(input int k);
        repeat (k) @(posedge clk_i);
        #10;
    endtask : step

    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task results;
        $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    // Count edges until the system reset shows a level, bounded
    task wait_rst(input logic lvl, output int k);
        k = 0;
        while (srst !== lvl) begin
            if (k == 60) begin
                n_mismatch++;
                $display("ERROR t=%0t wait got=%h exp=%h", $time, srst, lvl);
                results();
            end
            step(1);
            k++;
        end
    endtask : wait_rst

    // ************************************************************
    // Scenarios
    // ************************************************************
    task t_reset_vals;
        chk(16'(srst), 16'h1);
        chk(16'(oe), 16'h1);
        chk(16'(wdc), 16'(RSC_WDCTL_RESET));
        chk(16'(ring), 16'h1);
        chk(16'(irq), 16'h0);
        chk(16'(pin_val), 16'h0);
    endtask : t_reset_vals

    task t_powerup;
        core_ok = 1'b1;
        io_ok = 1'b1;
        wait_rst(1'b0, n);
        chk(16'(n), 16'(PU + 3));
        chk(16'(boot), 16'h1);
        chk(fa, RSC_RESET_VECTOR);
        chk(16'(oe), 16'h0);
    endtask : t_powerup

    // Software clears flag and ring select, a power-on reset sets them
    task t_por_again;
        pclr = 1'b1;
        csw = 1'b1;
        step(1);
        pclr = 1'b0;
        csw = 1'b0;
        step(1);
        chk(16'(wdc), 16'h0);
        chk(16'(ring), 16'h0);
        rstn_i = 1'b0;
        step(2);
        t_reset_vals();
        rstn_i = 1'b1;
        wait_rst(1'b0, n);
        chk(16'(n), 16'(PU + 3));
    endtask : t_por_again

    task t_pfail;
        pfail = 1'b1;
        wait_rst(1'b1, n);
        chk(16'(n), 16'h3);
        chk(16'(oe), 16'h1);
        pfail = 1'b0;
        wait_rst(1'b0, n);
        chk(16'(n), 16'h3);
        chk(16'(boot), 16'h1);
    endtask : t_pfail

    task t_wdt_irq;
        ien = 1'b1;
        wen = 1'b1;
        n = 0;
        while (irq !== 1'b1 && n < 40) begin
            step(1);
            n++;
        end
        if (irq !== 1'b1) begin
            n_mismatch++;
            $display("ERROR t=%0t irq got=%h exp=%h", $time, irq, 1'b1);
            results();
        end
        chk(16'(n), 16'(WD));
        chk(16'(srst), 16'h0);
        wait_rst(1'b1, n);
        chk(16'(n), 16'(WD));
        chk(16'(oe), 16'h1);
        wen = 1'b0;
        ien = 1'b0;
        wait_rst(1'b0, n);
        chk(16'(n), 16'h4);
        chk(16'(boot), 16'h1);
        chk(fa, RSC_RESET_VECTOR);
    endtask : t_wdt_irq

    // Timely restarts keep reset away; stopping them lets it expire
    task t_wdt_restart;
        wen = 1'b1;
        ien = 1'b1;
        repeat (6) begin
            step(WD - 3);
            wrs = 1'b1;
            step(1);
            wrs = 1'b0;
        end
        chk(16'(srst), 16'h0);
        chk(16'(irq), 16'h0);
        wait_rst(1'b1, n);
        chk(16'(n), 16'(2 * WD));
        wen = 1'b0;
        ien = 1'b0;
        wait_rst(1'b0, n);
        chk(16'(n), 16'h4);
    endtask : t_wdt_restart

    task t_manual;
        step(5);
        i_rsc_supervisor.hold_low(3);
        step(8);
        chk(16'(srst), 16'h0);
        i_rsc_supervisor.hold_low(6);
        chk(16'(srst), 16'h1);
        chk(16'(oe), 16'h0);
        wait_rst(1'b0, n);
        chk(16'(n <= 4), 16'h1);
        chk(16'(boot), 16'h1);
        chk(fa, RSC_RESET_VECTOR);
    endtask : t_manual

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        n_mismatch = 0;
        tests_run = 0;
        rstn_i = 1'b0;
        core_ok = 1'b0;
        io_ok = 1'b0;
        pfail = 1'b0;
        wen = 1'b0;
        ien = 1'b0;
        wrs = 1'b0;
        pclr = 1'b0;
        csw = 1'b0;
        step(12);
        t_reset_vals();
        rstn_i = 1'b1;
        step(4);
        chk(16'(srst), 16'h1);
        t_powerup();
        t_por_again();
        t_pfail();
        t_wdt_irq();
        t_wdt_restart();
        t_manual();
        results();
    end
endmodule : test_reset_source_controller
